// ==== rtl/pcg_pkg.sv ====
// Behaviour
// - Cycle-type bit of target-address register picks Type 0 or Type 1 cycle.
// - With abort-success enable set, a master-aborted cycle still reports success.
// - Type 1 address phase drives all 32 target-address bits onto the bus.
// - Type 0 address phase drives lines 31..16 one-hot, line 16+N high.
// - Type 0 lines 15..11 zero, 10..8 function, 7..2 register, 1..0 zero.
// - Data-window access is delayed: retry the master, then run the cycle.
// - While a cycle is outstanding, every further configuration access is retried.
// - Byte enables come from the low address bits and transfer-size signals.
// - Read data is latched; the repeated access at the same address completes.
// - A window write completes only after the configuration write has finished.
// - A designated register read produces an interrupt-acknowledge cycle.
// - Window read gives configuration read, window write gives configuration write.
package pcg_pkg;
  // Register byte offsets.
  localparam logic [11:0] ADDR_TARGET = 12'h000;
  localparam logic [11:0] ADDR_WINDOW = 12'h004;
  localparam logic [11:0] ADDR_MISC = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_INTACK = 12'h010;
  // Field positions.
  localparam int TYPE_BIT = 0;
  localparam int REG_LSB = 2;
  localparam int FUNC_LSB = 8;
  localparam int DEV_LSB = 11;
  localparam int MASE_BIT = 0;
  localparam int BME_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ABORT_BIT = 2;
  // Reset values.
  localparam logic [31:0] TARGET_RST = 32'h0000_0000;
  localparam logic [31:0] MISC_RST = 32'h0000_0000;
  // Bus commands and answers.
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_INTACK = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Link clocks waited for a target claim before master-abort.
  localparam logic [2:0] DEVSEL_WAIT = 3'h5;
  typedef enum {DT_IDLE, DT_PEND, DT_DONE} pcg_dt_e;
  typedef enum {P_IDLE, P_ADDR, P_DATA, P_TURN} pcg_pci_e;
  typedef enum logic [1:0] {K_RD, K_WR, K_IA} pcg_kind_e;
endpackage

// ==== rtl/pcg_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser; the first stage feeds only the second.
module pcg_sync #(
  parameter int W = 1
) (
  // Destination clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Data.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // Both stages clear on reset so toggles start equal.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule // pcg_sync

// ==== rtl/pcg_cfg_gen.sv ====
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module pcg_cfg_gen (
  // System clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // AXI4-Lite write channels.
  input wire logic [11:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // AXI4-Lite read channels.
  input wire logic [11:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // Processor-side sideband.
  input wire logic [1:0] transfer_size_i,
  output logic retry_o,
  // PCI link.
  input wire logic pci_clk_i,
  input wire logic [31:0] pci_ad_i,
  output logic [31:0] pci_ad_o,
  output logic pci_ad_oe_o,
  output logic [3:0] pci_cbe_n_o,
  output logic pci_cbe_oe_o,
  output logic pci_frame_n_o,
  output logic pci_frame_oe_o,
  output logic pci_irdy_n_o,
  output logic pci_irdy_oe_o,
  input wire logic pci_devsel_n_i,
  input wire logic pci_trdy_n_i,
  input wire logic pci_stop_n_i
);
  // System-domain state.
  logic [31:0] tgt_ff, misc_ff, wdata_ff, pa_ff, rdata_ff;
  logic [11:0] key_addr_ff;
  logic [3:0] be_ff, cmd_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, retry_ff;
  logic req_tog_ff, ack_seen_ff, ack_s;
  pcg_pkg::pcg_dt_e dt_ff;
  pcg_pkg::pcg_kind_e kind_ff, acc_kind;
  // Link-domain state.
  pcg_pkg::pcg_pci_e ps_ff;
  logic [31:0] ad_ff, res_data_ff;
  logic [3:0] cbe_ff;
  logic [2:0] cnt_ff;
  logic ad_oe_ff, cbe_oe_ff, frame_ff, frame_oe_ff, irdy_ff, irdy_oe_ff;
  logic res_abort_ff, ack_tog_ff, req_seen_ff, req_s, prst;
  // Decode terms.
  logic busy, wr_go, rd_go, dt_hit, dt_start, dt_finish, mase;
  logic [11:0] acc_addr;
  logic [9:0] word;
  logic [3:0] acc_be, lanes;
  logic [3:0] dev_sel;
  logic [2:0] fn_sel;
  logic [5:0] reg_sel;

  assign dev_sel = tgt_ff[pcg_pkg::DEV_LSB +: 4];
  assign fn_sel = tgt_ff[pcg_pkg::FUNC_LSB +: 3];
  assign reg_sel = tgt_ff[pcg_pkg::REG_LSB +: 6];
  assign mase = misc_ff[pcg_pkg::MASE_BIT];

  // Crossings: request and answer toggles, and the link-side reset.
  pcg_sync #(.W(1)) u_req_sync (.clk_i(pci_clk_i), .srst_i(prst),
    .d_i(req_tog_ff), .q_o(req_s));
  pcg_sync #(.W(1)) u_ack_sync (.clk_i(clk_i), .srst_i(srst_i),
    .d_i(ack_tog_ff), .q_o(ack_s));
  pcg_sync #(.W(1)) u_rst_sync (.clk_i(pci_clk_i), .srst_i(1'b0),
    .d_i(srst_i), .q_o(prst));

  // Byte lanes of the access; size 00 means a full word.
  always_comb begin
    case (transfer_size_i)
      2'h1: lanes = 4'h1;
      2'h2: lanes = 4'h3;
      2'h3: lanes = 4'h7;
      default: lanes = 4'hf;
    endcase
  end

  // One access at a time; a write offered with its data wins over a read.
  always_comb begin
    busy = awready_ff | arready_ff | bvalid_ff | rvalid_ff;
    wr_go = !busy && s_awvalid_i && s_wvalid_i;
    rd_go = !busy && s_arvalid_i && !wr_go;
    acc_addr = wr_go ? s_awaddr_i : s_araddr_i;
    word = acc_addr[11:2];
    acc_be = 4'((lanes << acc_addr[1:0]) & 5'h0f);
    if (wr_go) begin
      acc_kind = pcg_pkg::K_WR;
    end else if (word == pcg_pkg::ADDR_INTACK[11:2]) begin
      acc_kind = pcg_pkg::K_IA;
    end else begin
      acc_kind = pcg_pkg::K_RD;
    end
    dt_hit = (wr_go || rd_go) && (word == pcg_pkg::ADDR_WINDOW[11:2] ||
      (rd_go && word == pcg_pkg::ADDR_INTACK[11:2]));
    dt_start = dt_hit && dt_ff == pcg_pkg::DT_IDLE;
    dt_finish = dt_hit && dt_ff == pcg_pkg::DT_DONE && acc_kind == kind_ff
      && acc_addr == key_addr_ff && acc_be == be_ff;
  end

  // Delayed-transaction tracker and the snapshot handed to the link side.
  // The snapshot stays put until the answer toggle returns, so the link
  // domain may read it as a stable word.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dt_ff <= pcg_pkg::DT_IDLE;
      kind_ff <= pcg_pkg::K_RD;
      key_addr_ff <= '0;
      be_ff <= '0;
      cmd_ff <= '0;
      pa_ff <= '0;
      wdata_ff <= '0;
      req_tog_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
    end else begin
      if (dt_start) begin
        dt_ff <= pcg_pkg::DT_PEND;
        kind_ff <= acc_kind;
        key_addr_ff <= acc_addr;
        be_ff <= acc_be;
        wdata_ff <= s_wdata_i;
        req_tog_ff <= !req_tog_ff;
        if (acc_kind == pcg_pkg::K_IA) begin
          cmd_ff <= pcg_pkg::CMD_INTACK;
          pa_ff <= '0;
        end else begin
          cmd_ff <= (acc_kind == pcg_pkg::K_WR) ? pcg_pkg::CMD_CFG_WR
            : pcg_pkg::CMD_CFG_RD;
          if (tgt_ff[pcg_pkg::TYPE_BIT]) begin
            pa_ff <= tgt_ff;
          end else begin
            pa_ff <= {16'h0001 << dev_sel, 5'h00, fn_sel, reg_sel,
              2'h0};
          end
        end
      end else if (dt_ff == pcg_pkg::DT_PEND && ack_s != ack_seen_ff) begin
        dt_ff <= pcg_pkg::DT_DONE;
        ack_seen_ff <= ack_s;
      end else if (dt_finish) begin
        dt_ff <= pcg_pkg::DT_IDLE;
      end
    end
  end

  // Software-writable registers; byte strobes honoured.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tgt_ff <= pcg_pkg::TARGET_RST;
      misc_ff <= pcg_pkg::MISC_RST;
    end else if (wr_go) begin
      for (int i = 0; i < 4; i++) begin
        if (s_wstrb_i[i] && word == pcg_pkg::ADDR_TARGET[11:2]) begin
          tgt_ff[8*i +: 8] <= s_wdata_i[8*i +: 8];
        end
        if (s_wstrb_i[i] && word == pcg_pkg::ADDR_MISC[11:2]) begin
          misc_ff[8*i +: 8] <= s_wdata_i[8*i +: 8];
        end
      end
    end
  end

  // Bus handshakes and answers. A retried window access answers OKAY
  // with retry_o high, since AXI has no retry code of its own.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      bresp_ff <= pcg_pkg::RESP_OKAY;
      rresp_ff <= pcg_pkg::RESP_OKAY;
      rdata_ff <= '0;
      retry_ff <= 1'b0;
    end else begin
      awready_ff <= wr_go;
      wready_ff <= wr_go;
      arready_ff <= rd_go;
      if (bvalid_ff && s_bready_i) begin
        bvalid_ff <= 1'b0;
        retry_ff <= 1'b0;
      end
      if (rvalid_ff && s_rready_i) begin
        rvalid_ff <= 1'b0;
        retry_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        retry_ff <= dt_hit && !dt_finish;
        if (dt_finish && res_abort_ff && !mase) begin
          bresp_ff <= pcg_pkg::RESP_SLVERR;
        end else if (dt_hit || word == pcg_pkg::ADDR_TARGET[11:2] ||
            word == pcg_pkg::ADDR_MISC[11:2] ||
            word == pcg_pkg::ADDR_STATUS[11:2]) begin
          bresp_ff <= pcg_pkg::RESP_OKAY;
        end else begin
          bresp_ff <= pcg_pkg::RESP_DECERR;
        end
      end
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        retry_ff <= dt_hit && !dt_finish;
        rresp_ff <= pcg_pkg::RESP_OKAY;
        rdata_ff <= '0;
        if (dt_hit) begin
          if (dt_finish) begin
            rdata_ff <= res_data_ff;
            if (res_abort_ff && !mase) begin
              rresp_ff <= pcg_pkg::RESP_SLVERR;
            end
          end
        end else if (word == pcg_pkg::ADDR_TARGET[11:2]) begin
          rdata_ff <= tgt_ff;
        end else if (word == pcg_pkg::ADDR_MISC[11:2]) begin
          rdata_ff <= misc_ff;
        end else if (word == pcg_pkg::ADDR_STATUS[11:2]) begin
          rdata_ff[pcg_pkg::ST_BUSY_BIT] <= dt_ff == pcg_pkg::DT_PEND;
          rdata_ff[pcg_pkg::ST_DONE_BIT] <= dt_ff == pcg_pkg::DT_DONE;
          rdata_ff[pcg_pkg::ST_ABORT_BIT] <= dt_ff == pcg_pkg::DT_DONE &&
            res_abort_ff;
        end else begin
          rresp_ff <= pcg_pkg::RESP_DECERR;
        end
      end
    end
  end

  // Link master: address phase, one data phase, turnaround. A target
  // retry (stop without trdy) leaves the request unseen, so it reruns.
  always_ff @(posedge pci_clk_i) begin
    if (prst) begin
      ps_ff <= pcg_pkg::P_IDLE;
      ad_ff <= '0;
      cbe_ff <= 4'hf;
      cnt_ff <= '0;
      ad_oe_ff <= 1'b0;
      cbe_oe_ff <= 1'b0;
      frame_ff <= 1'b1;
      frame_oe_ff <= 1'b0;
      irdy_ff <= 1'b1;
      irdy_oe_ff <= 1'b0;
      res_data_ff <= '0;
      res_abort_ff <= 1'b0;
      ack_tog_ff <= 1'b0;
      req_seen_ff <= 1'b0;
    end else begin
      case (ps_ff)
        pcg_pkg::P_IDLE: begin
          if (req_s != req_seen_ff) begin
            ps_ff <= pcg_pkg::P_ADDR;
            ad_ff <= pa_ff;
            cbe_ff <= cmd_ff;
            ad_oe_ff <= 1'b1;
            cbe_oe_ff <= 1'b1;
            frame_ff <= 1'b0;
            frame_oe_ff <= 1'b1;
            irdy_ff <= 1'b1;
            irdy_oe_ff <= 1'b1;
          end
        end
        pcg_pkg::P_ADDR: begin
          ps_ff <= pcg_pkg::P_DATA;
          frame_ff <= 1'b1;
          irdy_ff <= 1'b0;
          cbe_ff <= ~be_ff;
          ad_ff <= wdata_ff;
          ad_oe_ff <= cmd_ff == pcg_pkg::CMD_CFG_WR;
          cnt_ff <= '0;
        end
        pcg_pkg::P_DATA: begin
          if (!pci_trdy_n_i && !pci_devsel_n_i) begin
            res_data_ff <= pci_ad_i;
            res_abort_ff <= 1'b0;
            ack_tog_ff <= !ack_tog_ff;
            req_seen_ff <= req_s;
            ps_ff <= pcg_pkg::P_TURN;
          end else if (!pci_stop_n_i && !pci_devsel_n_i) begin
            ps_ff <= pcg_pkg::P_TURN;
          end else if (pci_devsel_n_i && cnt_ff == pcg_pkg::DEVSEL_WAIT) begin
            res_data_ff <= 32'hffff_ffff;
            res_abort_ff <= 1'b1;
            ack_tog_ff <= !ack_tog_ff;
            req_seen_ff <= req_s;
            ps_ff <= pcg_pkg::P_TURN;
          end else begin
            cnt_ff <= cnt_ff + 3'h1;
          end
          if (ps_ff != pcg_pkg::P_DATA || !pci_trdy_n_i || !pci_stop_n_i
              || (pci_devsel_n_i && cnt_ff == pcg_pkg::DEVSEL_WAIT)) begin
            irdy_ff <= 1'b1;
            ad_oe_ff <= 1'b0;
          end
        end
        default: begin
          ps_ff <= pcg_pkg::P_IDLE;
          cbe_oe_ff <= 1'b0;
          frame_oe_ff <= 1'b0;
          irdy_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign s_awready_o = awready_ff;
  assign s_wready_o = wready_ff;
  assign s_bvalid_o = bvalid_ff;
  assign s_bresp_o = bresp_ff;
  assign s_arready_o = arready_ff;
  assign s_rvalid_o = rvalid_ff;
  assign s_rresp_o = rresp_ff;
  assign s_rdata_o = rdata_ff;
  assign retry_o = retry_ff;
  assign pci_ad_o = ad_ff;
  assign pci_ad_oe_o = ad_oe_ff;
  assign pci_cbe_n_o = cbe_ff;
  assign pci_cbe_oe_o = cbe_oe_ff;
  assign pci_frame_n_o = frame_ff;
  assign pci_frame_oe_o = frame_oe_ff;
  assign pci_irdy_n_o = irdy_ff;
  assign pci_irdy_oe_o = irdy_oe_ff;

  // Checks on the tracker and the link phases.
  property p_type1_addr;
    @(posedge clk_i) disable iff (srst_i)
    dt_start && acc_kind != pcg_pkg::K_IA && tgt_ff[pcg_pkg::TYPE_BIT]
    |=> pa_ff == $past(tgt_ff);
  endproperty
  a_type1_addr: assert property (p_type1_addr) else $error("bad type 1");
  property p_type0_dev;
    @(posedge clk_i) disable iff (srst_i)
    dt_start && acc_kind != pcg_pkg::K_IA && !tgt_ff[pcg_pkg::TYPE_BIT]
    |=> pa_ff[31:16] == 16'h0001 << $past(dev_sel);
  endproperty
  a_type0_dev: assert property (p_type0_dev) else $error("bad select");
  property p_type0_low;
    @(posedge clk_i) disable iff (srst_i)
    dt_start && acc_kind != pcg_pkg::K_IA && !tgt_ff[pcg_pkg::TYPE_BIT]
    |=> pa_ff[15:0] == {5'h00, $past(fn_sel), $past(reg_sel), 2'h0};
  endproperty
  a_type0_low: assert property (p_type0_low) else $error("bad low");
  property p_window_retry;
    @(posedge clk_i) disable iff (srst_i)
    dt_start |=> retry_ff && dt_ff == pcg_pkg::DT_PEND;
  endproperty
  a_window_retry: assert property (p_window_retry) else $error("no retry");
  property p_busy_retry;
    @(posedge clk_i) disable iff (srst_i)
    dt_hit && dt_ff == pcg_pkg::DT_PEND |=> retry_ff;
  endproperty
  a_busy_retry: assert property (p_busy_retry) else $error("not retried");
  property p_read_data;
    @(posedge clk_i) disable iff (srst_i)
    dt_finish && rd_go |=> s_rvalid_o && !retry_ff && s_rdata_o == res_data_ff;
  endproperty
  a_read_data: assert property (p_read_data) else $error("bad read");
  property p_ma_ok;
    @(posedge clk_i) disable iff (srst_i)
    dt_finish && wr_go && res_abort_ff && mase |=> s_bresp_o == 2'h0;
  endproperty
  a_ma_ok: assert property (p_ma_ok) else $error("abort not hidden");
  property p_ma_err;
    @(posedge clk_i) disable iff (srst_i)
    dt_finish && rd_go && res_abort_ff && !mase |=> s_rresp_o == 2'h2;
  endproperty
  a_ma_err: assert property (p_ma_err) else $error("no bus error");
  property p_wr_after;
    @(posedge clk_i) disable iff (srst_i)
    wr_go && dt_hit && dt_ff != pcg_pkg::DT_DONE |=> retry_ff;
  endproperty
  a_wr_after: assert property (p_wr_after) else $error("early write");
  property p_be_phase;
    @(posedge pci_clk_i) disable iff (prst)
    ps_ff == pcg_pkg::P_ADDR |-> pci_ad_o == pa_ff && pci_cbe_n_o == cmd_ff
      ##1 pci_cbe_n_o == ~be_ff && !pci_irdy_n_o;
  endproperty
  a_be_phase: assert property (p_be_phase) else $error("bad phase");
  property p_intack;
    @(posedge clk_i) disable iff (srst_i)
    dt_start && acc_kind == pcg_pkg::K_IA |=> cmd_ff == 4'h0;
  endproperty
  a_intack: assert property (p_intack) else $error("bad intack");
  c_type0: cover property (@(posedge clk_i) disable iff (srst_i)
    dt_start && !tgt_ff[pcg_pkg::TYPE_BIT]);
  c_read_done: cover property (@(posedge clk_i) disable iff (srst_i)
    dt_finish && rd_go);
  c_abort: cover property (@(posedge pci_clk_i) disable iff (prst)
    ps_ff == pcg_pkg::P_DATA && pci_devsel_n_i &&
    cnt_ff == pcg_pkg::DEVSEL_WAIT);
endmodule // pcg_cfg_gen

// ==== bench/pcg_pci_target.sv ====
`timescale 1ns/1ps
// Behavioural configuration target on the link: claims after a chosen wait,
// or never, so that the bridge is driven into master-abort.
module pcg_pci_target (
  // Link clock and scenario controls.
  input wire logic pci_clk_i,
  input wire logic abort_i,
  input wire logic [2:0] wait_i,
  input wire logic [31:0] rdata_i,
  input wire logic retry_i,
  // Bus as seen on the wires.
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_n_i,
  input wire logic frame_n_i,
  input wire logic frame_oe_i,
  input wire logic irdy_n_i,
  // Target drive.
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  output logic devsel_n_o,
  output logic trdy_n_o,
  output logic stop_n_o,
  // Last cycle seen.
  output logic [31:0] addr_o,
  output logic [3:0] cmd_o,
  output logic [3:0] be_n_o,
  output logic [31:0] wdata_o
);
  logic act_ff;
  logic [2:0] cnt_ff;
  logic rty_ff;

  // Released control lines sit at their pull-up level.
  initial begin
    act_ff = 1'b0;
    cnt_ff = 3'h0;
    ad_o = 32'h0;
    ad_oe_o = 1'b0;
    devsel_n_o = 1'b1;
    trdy_n_o = 1'b1;
    stop_n_o = 1'b1;
    rty_ff = 1'b0;
  end

  // Address capture, claim after the wait, data transfer and release.
  always @(posedge pci_clk_i) begin
    if (!act_ff) begin
      if (frame_oe_i && !frame_n_i) begin
        act_ff <= 1'b1;
        addr_o <= ad_i;
        cmd_o <= cbe_n_i;
        cnt_ff <= 3'h0;
        rty_ff <= rty_ff & retry_i;
      end
    end else if (!trdy_n_o && !irdy_n_i) begin
      be_n_o <= cbe_n_i;
      wdata_o <= ad_i;
      act_ff <= 1'b0;
      devsel_n_o <= 1'b1;
      trdy_n_o <= 1'b1;
      ad_oe_o <= 1'b0;
    end else if (!stop_n_o) begin
      // Target retry: the master must rerun the whole cycle.
      act_ff <= 1'b0;
      devsel_n_o <= 1'b1;
      stop_n_o <= 1'b1;
    end else if (cnt_ff != 3'h0 && irdy_n_i) begin
      act_ff <= 1'b0; // The master has given up.
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      if (!abort_i && cnt_ff >= wait_i && retry_i && !rty_ff) begin
        devsel_n_o <= 1'b0;
        stop_n_o <= 1'b0;
        rty_ff <= 1'b1;
      end else if (!abort_i && cnt_ff >= wait_i) begin
        devsel_n_o <= 1'b0;
        trdy_n_o <= 1'b0;
        ad_o <= rdata_i;
        ad_oe_o <= (cmd_o != pcg_pkg::CMD_CFG_WR);
      end
    end
  end
endmodule // pcg_pci_target

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  typedef struct {
    logic [1:0] c;
    logic w;
    logic [1:0] resp;
    logic rt;
    logic [31:0] d;
  } pcg_exp_s;
  logic clk_i = 1'b0, pci_clk_i = 1'b0, srst_i = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, abort = 1'b0;
  logic [31:0] wdata = 32'h0, t_rdata = 32'h0, pat = 32'h5a5a_0f0f;
  logic [1:0] tsize = 2'h0;
  logic [2:0] wt = 3'h0;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic retry_o, ad_oe, cbe_oe, frame_n, frame_oe, irdy_n, irdy_oe;
  logic devsel_n, trdy_n, t_oe, stop_n;
  logic rty = 1'b0;
  logic [1:0] s_bresp_o, s_rresp_o;
  logic [31:0] s_rdata_o, ad_o, t_ad, pci_ad_i, cap_addr, cap_wd;
  logic [3:0] cbe_n, cap_cmd, cap_be;
  pcg_exp_s expq[$];
  pcg_exp_s e;
  int mismatches = 0, tests_run = 0;

  // Clocks of unrelated phase; the link clock runs free as on a real bus.
  always #5 clk_i = ~clk_i;
  initial #13 forever #40 pci_clk_i = ~pci_clk_i;

  // Undriven address lines show a pattern that changes every link clock.
  always @(posedge pci_clk_i) pat <= {pat[30:0], ~pat[31]};
  assign pci_ad_i = ad_oe ? ad_o : (t_oe ? t_ad : pat);

  pcg_cfg_gen dut (.clk_i(clk_i), .srst_i(srst_i),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(s_awready_o),
    .s_wdata_i(wdata), .s_wstrb_i(4'hf), .s_wvalid_i(wvalid),
    .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o),
    .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
    .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o),
    .s_rvalid_o(s_rvalid_o), .s_rready_i(rready), .transfer_size_i(tsize),
    .retry_o(retry_o), .pci_clk_i(pci_clk_i), .pci_ad_i(pci_ad_i),
    .pci_ad_o(ad_o), .pci_ad_oe_o(ad_oe), .pci_cbe_n_o(cbe_n),
    .pci_cbe_oe_o(cbe_oe), .pci_frame_n_o(frame_n), .pci_frame_oe_o(frame_oe),
    .pci_irdy_n_o(irdy_n), .pci_irdy_oe_o(irdy_oe),
    .pci_devsel_n_i(devsel_n), .pci_trdy_n_i(trdy_n), .pci_stop_n_i(stop_n));

  pcg_pci_target tgt (.pci_clk_i(pci_clk_i), .abort_i(abort), .wait_i(wt),
    .rdata_i(t_rdata), .retry_i(rty), .stop_n_o(stop_n),
    .ad_i(pci_ad_i), .cbe_n_i(cbe_n), .frame_n_i(frame_n),
    .frame_oe_i(frame_oe), .irdy_n_i(irdy_n), .ad_o(t_ad), .ad_oe_o(t_oe),
    .devsel_n_o(devsel_n), .trdy_n_o(trdy_n), .addr_o(cap_addr),
    .cmd_o(cap_cmd), .be_n_o(cap_be), .wdata_o(cap_wd));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [3:0] lanes(input logic [1:0] sz,
                                       input logic [1:0] off);
    logic [3:0] m;
    m = (sz == 2'h0) ? 4'hf : (sz == 2'h1) ? 4'h1 : (sz == 2'h2) ? 4'h3 : 4'h7;
    return m << off;
  endfunction

  task automatic final_report();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One register access; the expected answer is noted before it starts.
  task automatic acc(input logic w, input logic [11:0] a, input logic [1:0] sz,
    input logic [31:0] d, input logic [1:0] c, input logic [1:0] er,
    input logic et, input logic [31:0] ed, output logic [31:0] q);
    int n;
    n = 0;
    expq.push_back('{c, w, er, et, ed});
    @(posedge clk_i);
    tsize <= sz;
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      @(posedge clk_i);
      n++;
    end while (!(w ? s_bvalid_o : s_rvalid_o) && n < 500);
    q = s_rdata_o;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
    if (n >= 500) begin
      mismatches++;
      final_report();
    end
  endtask

  // Delayed transaction: retried, retried while pending, polled, completed.
  task automatic cfg(input logic w, input logic [11:0] a, input logic [1:0] sz,
    input logic [31:0] d, input logic [1:0] er, input logic [31:0] ed);
    logic [31:0] q;
    int n;
    acc(w, a, sz, d, 2'h1, pcg_pkg::RESP_OKAY, 1'b1, 32'h0, q);
    acc(w, a, sz, d, 2'h1, pcg_pkg::RESP_OKAY, 1'b1, 32'h0, q);
    q = 32'h0;
    for (n = 0; n < 100 && !q[pcg_pkg::ST_DONE_BIT]; n++)
      acc(1'b0, pcg_pkg::ADDR_STATUS, 2'h0, 32'h0, 2'h0, 2'h0, 1'b0, 32'h0, q);
    if (n >= 100) begin
      mismatches++;
      final_report();
    end
    acc(w, a, sz, d, 2'h2, er, 1'b0, ed, q);
  endtask

  // Each answer pops the oldest note at its handshake; all but the status polls are then compared with it.
  always @(posedge clk_i) begin
    if ((s_rvalid_o && rready) || (s_bvalid_o && bready)) begin
      e = expq.pop_front();
      if (e.c != 2'h0) begin
        `CHK("resp", e.resp, e.w ? s_bresp_o : s_rresp_o)
        `CHK("retry", e.rt, retry_o)
      end
      if (e.c == 2'h2 && !e.w)
        `CHK("rdata", e.d, s_rdata_o)
    end
  end

  // Main sequence; reset is held long enough for the link side as well.
  initial begin
    logic [15:0] r;
    logic [31:0] tg, q, rd;
    logic [1:0] off;
    r = 16'h0290;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    // The link-side reset lags by two link clocks, so wait before the first access.
    repeat (40) @(posedge clk_i);
    acc(1'b0, pcg_pkg::ADDR_TARGET, 2'h0, 32'h0, 2'h2, pcg_pkg::RESP_OKAY,
        1'b0, pcg_pkg::TARGET_RST, q);
    acc(1'b0, pcg_pkg::ADDR_MISC, 2'h0, 32'h0, 2'h2, pcg_pkg::RESP_OKAY,
        1'b0, pcg_pkg::MISC_RST, q);
    acc(1'b0, 12'h020, 2'h0, 32'h0, 2'h1, pcg_pkg::RESP_DECERR, 1'b0, 32'h0, q);
    acc(1'b1, pcg_pkg::ADDR_MISC, 2'h0, 32'h2, 2'h1, 2'h0, 1'b0, 32'h0, q);
    // Type 0 reads across every device select value.
    for (int dv = 0; dv < 16; dv++) begin
      r = lfsr(r);
      tg = {17'h0, 4'(dv), r[2:0], r[8:3], 2'h0};
      acc(1'b1, pcg_pkg::ADDR_TARGET, 2'h0, tg, 2'h1, 2'h0, 1'b0, 32'h0, q);
      rd = {r, ~r};
      t_rdata <= rd;
      wt <= 3'(dv % 4);
      rty <= (dv == 5);
      cfg(1'b0, pcg_pkg::ADDR_WINDOW, 2'h0, 32'h0, pcg_pkg::RESP_OKAY, rd);
      `CHK("addr0", (32'h1 << (16 + dv)) | {21'h0, r[2:0], r[8:3], 2'h0}, cap_addr)
      `CHK("cmd_rd", pcg_pkg::CMD_CFG_RD, cap_cmd)
      `CHK("be_rd", 4'h0, cap_be)
    end
    // Type 1 writes, each transfer size at a random lane offset.
    for (int sz = 0; sz < 4; sz++) begin
      r = lfsr(r);
      tg = {r, r} | 32'h1;
      off = r[1:0];
      acc(1'b1, pcg_pkg::ADDR_TARGET, 2'h0, tg, 2'h1, 2'h0, 1'b0, 32'h0, q);
      cfg(1'b1, pcg_pkg::ADDR_WINDOW | {10'h0, off}, 2'(sz), {~r, r},
          pcg_pkg::RESP_OKAY, 32'h0);
      `CHK("addr1", tg, cap_addr)
      `CHK("cmd_wr", pcg_pkg::CMD_CFG_WR, cap_cmd)
      `CHK("wdata", {~r, r}, cap_wd)
      `CHK("be_wr", ~lanes(2'(sz), off), cap_be)
    end
    // Master-abort with the success enable clear, then set.
    abort <= 1'b1;
    cfg(1'b0, pcg_pkg::ADDR_WINDOW, 2'h0, 32'h0, pcg_pkg::RESP_SLVERR,
        32'hffff_ffff);
    acc(1'b1, pcg_pkg::ADDR_MISC, 2'h0, 32'h3, 2'h1, 2'h0, 1'b0, 32'h0, q);
    cfg(1'b0, pcg_pkg::ADDR_WINDOW, 2'h0, 32'h0, pcg_pkg::RESP_OKAY,
        32'hffff_ffff);
    abort <= 1'b0;
    // Interrupt acknowledge through its designated read.
    r = lfsr(r);
    t_rdata <= {~r, r};
    cfg(1'b0, pcg_pkg::ADDR_INTACK, 2'h0, 32'h0, pcg_pkg::RESP_OKAY, {~r, r});
    `CHK("cmd_ia", pcg_pkg::CMD_INTACK, cap_cmd)
    repeat (4) @(posedge clk_i);
    final_report();
  end
endmodule // tb
